// ---- design/adccfg_pkg.sv ----
// constants and types shared by the configuration register bank
package adccfg_pkg;

  // ==========================================================
  // byte addresses of the register bases
  localparam logic [7:0] CHAIN_IDENTIFIER_ADDR        = 8'h00;
  localparam logic [7:0] RESET_POWER_CONTROL_ADDR     = 8'h04;
  localparam logic [7:0] INPUT_PROTOCOL_CONTROL_ADDR  = 8'h08;
  localparam logic [7:0] OUTPUT_PROTOCOL_CONTROL_ADDR = 8'h0c;
  localparam logic [7:0] OUTPUT_WORD_CONTROL_ADDR     = 8'h10;
  localparam logic [7:0] INPUT_SPAN_SELECT_ADDR       = 8'h14;
  localparam logic [7:0] ALARM_FLAGS_ADDR             = 8'h20;
  localparam logic [7:0] ALARM_UPPER_LIMIT_ADDR       = 8'h24;
  localparam logic [7:0] ALARM_LOWER_LIMIT_ADDR       = 8'h28;

  // ==========================================================
  // byte lanes inside a word
  localparam logic [1:0] LANE_BITS_7_0   = 2'h0;
  localparam logic [1:0] LANE_BITS_15_8  = 2'h1;
  localparam logic [1:0] LANE_BITS_23_16 = 2'h2;
  localparam logic [1:0] LANE_BITS_31_24 = 2'h3;

  // ==========================================================
  // field positions, counted inside their byte lane, and generic storage sizes
  localparam int CHAIN_ID_LSB          = 0;
  localparam int CHAIN_ID_W            = 4;
  localparam int SUPPLY_ALARM_DIS_BIT  = 5;
  localparam int INPUT_ALARM_DIS_BIT   = 4;
  localparam int RESET_CLASS_BIT       = 2;
  localparam int LIGHT_SLEEP_EN_BIT    = 1;
  localparam int POWER_DOWN_BIT        = 0;
  localparam int PROTOCOL_LSB          = 0;
  localparam int PROTOCOL_W            = 2;
  localparam int GENERIC_WORDS         = 6;
  localparam int GENERIC_BYTES         = 24;

  // ==========================================================
  // key and reset values
  localparam logic [7:0]            WRITE_KEY_VALUE  = 8'h69;
  localparam logic [7:0]            KEY_RESET        = 8'h00;
  localparam logic [CHAIN_ID_W-1:0] CHAIN_ID_RESET   = 4'h0;
  localparam logic [PROTOCOL_W-1:0] PROTOCOL_RESET   = 2'h0;
  localparam logic                  CTRL_BIT_RESET   = 1'b0;
  localparam logic [7:0]            BYTE_RESET       = 8'h00;
  localparam logic [1:0]            PIN_IDLE_LEVELS  = 2'h3;

  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_LIGHT_SLEEP,
    PWR_DOWN
  } adccfg_pwr_t;

endpackage : adccfg_pkg

// ---- design/adccfg_pin_sync.sv ----
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
`default_nettype none

module adccfg_pin_sync #(
  parameter int         WIDTH = 2,
  parameter logic [1:0] IDLE  = 2'h3
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // a change is accepted only once stages two and three agree
  always_comb begin
    next_level = o_level;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stage1  <= IDLE[WIDTH-1:0];
      stage2  <= IDLE[WIDTH-1:0];
      stage3  <= IDLE[WIDTH-1:0];
      o_level <= IDLE[WIDTH-1:0];
    end else begin
      stage1  <= i_pin;
      stage2  <= stage1;
      stage3  <= stage2;
      o_level <= next_level;
    end
  end

endmodule : adccfg_pin_sync

`default_nettype wire

// ---- design/adccfg_regbank.sv ----
// configuration register bank with key-protected reset and power control
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - nine 32-bit registers, four byte addresses each
// - byte lanes map low to high addresses
// - writable 4-bit chain identifier, resets zero
// - reserved bits always read as zero
// - control bits written only with key 69h
// - bit five disables supply alarm
// - bit four disables input alarm
// - bit two selects reset pin class
// - class bit sticks until power cycle
// - light sleep after conversion done when enabled and select high
// - bit zero requests converter power down
// - class cleared only at power-on; sleep also at full pin reset
// - protocol field selects clock polarity/phase
module adccfg_regbank
  import adccfg_pkg::*;
(
  input  wire logic                  I_CLK,
  input  wire logic                  I_RST,
  input  wire logic                  I_WR_EN,
  input  wire logic                  I_RD_EN,
  input  wire logic [7:0]            I_ADDR,
  input  wire logic [7:0]            I_WR_DATA,
  input  wire logic                  I_RESET_PIN_N,
  input  wire logic                  I_CONVERT_START_SELECT,
  input  wire logic                  I_CONV_DONE,
  output logic      [7:0]            O_RD_DATA,
  output logic                       O_RD_VALID,
  output logic      [CHAIN_ID_W-1:0] O_CHAIN_ID,
  output logic      [PROTOCOL_W-1:0] O_SERIAL_PROTOCOL_SELECT,
  output logic                       O_SUPPLY_ALARM_EN,
  output logic                       O_INPUT_ALARM_EN,
  output logic                       O_POWER_DOWN,
  output logic                       O_LIGHT_SLEEP,
  output logic                       O_APP_RESET,
  output logic                       O_FULL_RESET
);

  // ==========================================================
  // state
  logic [CHAIN_ID_W-1:0] chain_id;
  logic [7:0]            write_protect_key;
  logic                  supply_alarm_disable;
  logic                  input_alarm_disable;
  logic                  reset_pin_class_select;
  logic                  light_sleep_enable;
  logic                  power_down_request;
  logic [PROTOCOL_W-1:0] serial_protocol_select;
  logic [7:0]            generic_mem [GENERIC_BYTES];
  adccfg_pwr_t           pwr;
  logic                  pin_prev_n;
  logic [7:0]            rd_data;
  logic                  rd_valid;
  logic                  app_reset;
  logic                  full_reset;

  logic [CHAIN_ID_W-1:0] next_chain_id;
  logic [7:0]            next_write_protect_key;
  logic                  next_supply_alarm_disable;
  logic                  next_input_alarm_disable;
  logic                  next_reset_pin_class_select;
  logic                  next_light_sleep_enable;
  logic                  next_power_down_request;
  logic [PROTOCOL_W-1:0] next_serial_protocol_select;
  logic [7:0]            next_generic_mem [GENERIC_BYTES];
  adccfg_pwr_t           next_pwr;
  logic [7:0]            next_rd_data;

  logic [1:0]            pin_level;
  logic                  reset_pin_n;
  logic                  select_high;
  logic                  pin_fall;
  logic [5:0]            wr_slot;
  logic [5:0]            rd_slot;

  // ==========================================================
  // pin synchronisers
  adccfg_pin_sync #(
    .WIDTH (2),
    .IDLE  (PIN_IDLE_LEVELS)
  ) u_pin_sync (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_pin   ({I_RESET_PIN_N, I_CONVERT_START_SELECT}),
    .o_level (pin_level)
  );

  assign reset_pin_n = pin_level[1];
  assign select_high = pin_level[0];
  assign pin_fall    = pin_prev_n & ~reset_pin_n;

  // ==========================================================
  // address decode
  // registers without documented fields are kept as plain bytes
  function automatic logic [5:0] generic_slot(input logic [7:0] a);
    logic [2:0] word;
    logic       hit;
    word = 3'h0;
    hit  = 1'b1;
    unique case ({a[7:2], 2'h0})
      OUTPUT_PROTOCOL_CONTROL_ADDR: word = 3'h0;
      OUTPUT_WORD_CONTROL_ADDR:     word = 3'h1;
      INPUT_SPAN_SELECT_ADDR:       word = 3'h2;
      ALARM_FLAGS_ADDR:             word = 3'h3;
      ALARM_UPPER_LIMIT_ADDR:       word = 3'h4;
      ALARM_LOWER_LIMIT_ADDR:       word = 3'h5;
      default:                      hit  = 1'b0;
    endcase
    return {hit, word, a[1:0]};
  endfunction : generic_slot

  function automatic logic at_byte(input logic [7:0] a, input logic [7:0] base, input logic [1:0] lane);
    return a == (base | {6'h00, lane});
  endfunction : at_byte

  assign wr_slot = generic_slot(I_ADDR);
  assign rd_slot = generic_slot(I_ADDR);

  // ==========================================================
  // register writes and reset classes
  always_comb begin
    next_chain_id               = chain_id;
    next_write_protect_key      = write_protect_key;
    next_supply_alarm_disable   = supply_alarm_disable;
    next_input_alarm_disable    = input_alarm_disable;
    next_reset_pin_class_select = reset_pin_class_select;
    next_light_sleep_enable     = light_sleep_enable;
    next_power_down_request     = power_down_request;
    next_serial_protocol_select = serial_protocol_select;
    next_generic_mem            = generic_mem;
    if (pin_fall) begin
      // both classes clear user settings; only the full class touches power-on fields
      next_chain_id             = CHAIN_ID_RESET;
      next_write_protect_key    = KEY_RESET;
      next_supply_alarm_disable = CTRL_BIT_RESET;
      next_input_alarm_disable  = CTRL_BIT_RESET;
      next_power_down_request   = CTRL_BIT_RESET;
      for (int i = 0; i < GENERIC_BYTES; i++) begin
        next_generic_mem[i] = BYTE_RESET;
      end
      if (!reset_pin_class_select) begin
        next_light_sleep_enable     = CTRL_BIT_RESET;
        next_serial_protocol_select = PROTOCOL_RESET;
      end
    end else if (I_WR_EN) begin
      if (at_byte(I_ADDR, CHAIN_IDENTIFIER_ADDR, LANE_BITS_23_16)) begin
        next_chain_id = I_WR_DATA[CHAIN_ID_LSB +: CHAIN_ID_W];
      end
      if (at_byte(I_ADDR, RESET_POWER_CONTROL_ADDR, LANE_BITS_15_8)) begin
        next_write_protect_key = I_WR_DATA;
      end
      if (at_byte(I_ADDR, RESET_POWER_CONTROL_ADDR, LANE_BITS_7_0) &&
          write_protect_key == WRITE_KEY_VALUE) begin
        next_supply_alarm_disable   = I_WR_DATA[SUPPLY_ALARM_DIS_BIT];
        next_input_alarm_disable    = I_WR_DATA[INPUT_ALARM_DIS_BIT];
        next_reset_pin_class_select = reset_pin_class_select | I_WR_DATA[RESET_CLASS_BIT];
        next_light_sleep_enable     = I_WR_DATA[LIGHT_SLEEP_EN_BIT];
        next_power_down_request     = I_WR_DATA[POWER_DOWN_BIT];
      end
      if (at_byte(I_ADDR, INPUT_PROTOCOL_CONTROL_ADDR, LANE_BITS_7_0)) begin
        next_serial_protocol_select = I_WR_DATA[PROTOCOL_LSB +: PROTOCOL_W];
      end
      if (wr_slot[5]) begin
        next_generic_mem[wr_slot[4:0]] = I_WR_DATA;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      chain_id               <= CHAIN_ID_RESET;
      write_protect_key      <= KEY_RESET;
      supply_alarm_disable   <= CTRL_BIT_RESET;
      input_alarm_disable    <= CTRL_BIT_RESET;
      reset_pin_class_select <= CTRL_BIT_RESET;
      light_sleep_enable     <= CTRL_BIT_RESET;
      power_down_request     <= CTRL_BIT_RESET;
      serial_protocol_select <= PROTOCOL_RESET;
      for (int i = 0; i < GENERIC_BYTES; i++) begin
        generic_mem[i] <= BYTE_RESET;
      end
    end else begin
      chain_id               <= next_chain_id;
      write_protect_key      <= next_write_protect_key;
      supply_alarm_disable   <= next_supply_alarm_disable;
      input_alarm_disable    <= next_input_alarm_disable;
      reset_pin_class_select <= next_reset_pin_class_select;
      light_sleep_enable     <= next_light_sleep_enable;
      power_down_request     <= next_power_down_request;
      serial_protocol_select <= next_serial_protocol_select;
      generic_mem            <= next_generic_mem;
    end
  end

  // ==========================================================
  // power state
  always_comb begin
    next_pwr = pwr;
    if (power_down_request) begin
      next_pwr = PWR_DOWN;
    end else begin
      unique case (pwr)
        PWR_ACTIVE: begin
          if (I_CONV_DONE && light_sleep_enable && select_high) begin
            next_pwr = PWR_LIGHT_SLEEP;
          end
        end
        PWR_LIGHT_SLEEP: begin
          if (!select_high || !light_sleep_enable) begin
            next_pwr = PWR_ACTIVE;
          end
        end
        PWR_DOWN: begin
          next_pwr = PWR_ACTIVE;
        end
        default: begin
          next_pwr = PWR_ACTIVE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      pwr        <= PWR_ACTIVE;
      pin_prev_n <= 1'b1;
      app_reset  <= 1'b0;
      full_reset <= 1'b0;
    end else begin
      pwr        <= next_pwr;
      pin_prev_n <= reset_pin_n;
      app_reset  <= pin_fall & reset_pin_class_select;
      full_reset <= pin_fall & ~reset_pin_class_select;
    end
  end

  // ==========================================================
  // read path; reserved and unmapped bytes return zero
  always_comb begin
    next_rd_data = BYTE_RESET;
    if (at_byte(I_ADDR, CHAIN_IDENTIFIER_ADDR, LANE_BITS_23_16)) begin
      next_rd_data[CHAIN_ID_LSB +: CHAIN_ID_W] = chain_id;
    end
    if (at_byte(I_ADDR, RESET_POWER_CONTROL_ADDR, LANE_BITS_15_8)) begin
      next_rd_data = write_protect_key;
    end
    if (at_byte(I_ADDR, RESET_POWER_CONTROL_ADDR, LANE_BITS_7_0)) begin
      next_rd_data[SUPPLY_ALARM_DIS_BIT] = supply_alarm_disable;
      next_rd_data[INPUT_ALARM_DIS_BIT]  = input_alarm_disable;
      next_rd_data[RESET_CLASS_BIT]      = reset_pin_class_select;
      next_rd_data[LIGHT_SLEEP_EN_BIT]   = light_sleep_enable;
      next_rd_data[POWER_DOWN_BIT]       = power_down_request;
    end
    if (at_byte(I_ADDR, INPUT_PROTOCOL_CONTROL_ADDR, LANE_BITS_7_0)) begin
      next_rd_data[PROTOCOL_LSB +: PROTOCOL_W] = serial_protocol_select;
    end
    if (rd_slot[5]) begin
      next_rd_data = generic_mem[rd_slot[4:0]];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rd_data  <= BYTE_RESET;
      rd_valid <= 1'b0;
    end else begin
      rd_data  <= I_RD_EN ? next_rd_data : rd_data;
      rd_valid <= I_RD_EN;
    end
  end

  assign O_RD_DATA                = rd_data;
  assign O_RD_VALID               = rd_valid;
  assign O_CHAIN_ID               = chain_id;
  assign O_SERIAL_PROTOCOL_SELECT = serial_protocol_select;
  assign O_SUPPLY_ALARM_EN        = ~supply_alarm_disable;
  assign O_INPUT_ALARM_EN         = ~input_alarm_disable;
  assign O_POWER_DOWN             = pwr == PWR_DOWN;
  assign O_LIGHT_SLEEP            = pwr == PWR_LIGHT_SLEEP;
  assign O_APP_RESET              = app_reset;
  assign O_FULL_RESET             = full_reset;

  // ==========================================================
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  key_gate_a: assert property (I_WR_EN && !pin_fall && I_ADDR == RESET_POWER_CONTROL_ADDR &&
      write_protect_key != WRITE_KEY_VALUE |=> $stable(power_down_request) && $stable(light_sleep_enable))
    else $error("control bits changed without key");
  key_write_a: assert property (I_WR_EN && !pin_fall && I_ADDR == RESET_POWER_CONTROL_ADDR &&
      write_protect_key == WRITE_KEY_VALUE |=> power_down_request == $past(I_WR_DATA[0]))
    else $error("keyed write to power down lost");
  chain_id_a: assert property (I_WR_EN && !pin_fall && I_ADDR == 8'h02 |=> O_CHAIN_ID == $past(I_WR_DATA[3:0]))
    else $error("chain identifier not written");
  reserved_zero_a: assert property (I_RD_EN && I_ADDR == 8'h03 |=> O_RD_VALID && O_RD_DATA == 8'h00)
    else $error("reserved byte read nonzero");
  class_sticky_a: assert property (reset_pin_class_select |=> reset_pin_class_select)
    else $error("reset class bit cleared");
  alarm_map_a: assert property (I_WR_EN && !pin_fall && I_ADDR == RESET_POWER_CONTROL_ADDR && write_protect_key ==
      WRITE_KEY_VALUE |=> O_SUPPLY_ALARM_EN == !$past(I_WR_DATA[5]) && O_INPUT_ALARM_EN == !$past(I_WR_DATA[4]))
    else $error("alarm enable polarity wrong");
  app_keep_a: assert property (pin_fall && reset_pin_class_select |=> light_sleep_enable == $past(light_sleep_enable)
      && chain_id == 4'h0 && O_APP_RESET)
    else $error("application reset cleared wrong fields");
  full_reset_a: assert property (pin_fall && !reset_pin_class_select |=> !light_sleep_enable && O_FULL_RESET)
    else $error("full reset class not applied");
  sleep_entry_a: assert property (!power_down_request && pwr == PWR_ACTIVE && I_CONV_DONE && light_sleep_enable &&
      select_high |=> O_LIGHT_SLEEP)
    else $error("light sleep not entered");
  power_down_a: assert property (power_down_request |=> O_POWER_DOWN ##1 (O_POWER_DOWN || !power_down_request))
    else $error("power down not reached");
  protocol_a: assert property (I_WR_EN && !pin_fall && I_ADDR == INPUT_PROTOCOL_CONTROL_ADDR
      |=> O_SERIAL_PROTOCOL_SELECT == $past(I_WR_DATA[1:0]))
    else $error("protocol select not written");

  keyed_write_c: cover property (I_WR_EN && I_ADDR == 8'h05 && I_WR_DATA == WRITE_KEY_VALUE
      ##1 I_WR_EN && I_ADDR == RESET_POWER_CONTROL_ADDR);
  app_reset_c: cover property (O_APP_RESET);
  light_sleep_c: cover property (O_LIGHT_SLEEP ##1 !O_LIGHT_SLEEP);

endmodule : adccfg_regbank

`default_nettype wire

// ---- tb/adccfg_host.sv ----
// host controller model that drives the byte register bus
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// byte bus host
module adccfg_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  output var  logic       o_wr_en,
  output var  logic       o_rd_en,
  output var  logic [7:0] o_addr,
  output var  logic [7:0] o_wr_data
);
  initial begin
    o_wr_en   = 1'b0;
    o_rd_en   = 1'b0;
    o_addr    = 8'h00;
    o_wr_data = 8'h00;
  end

  // released lines show the inverse so stale values never pass for live ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr_en   = 1'b1;
    o_addr    = a;
    o_wr_data = d;
    @(negedge i_clk);
    o_wr_en   = 1'b0;
    o_addr    = ~a;
    o_wr_data = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge i_clk);
    o_rd_en = 1'b1;
    o_addr  = a;
    @(negedge i_clk);
    o_rd_en = 1'b0;
    o_addr  = ~a;
    n = 0;
    while (i_rd_valid !== 1'b1 && n < 4) begin
      @(negedge i_clk);
      n++;
    end
    d = (i_rd_valid === 1'b1) ? i_rd_data : 8'hxx;
  endtask : rd

  // the unlock byte always precedes a control write
  task automatic key_wr(input logic [7:0] d);
    wr(8'h05, 8'h69);
    wr(8'h04, d);
  endtask : key_wr
endmodule : adccfg_host
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking testbench of the configuration register bank
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import adccfg_pkg::*;
  logic       clk, rst, pin_n, sel, done, wr_en, rd_en, rvalid;
  logic       sup_en, in_en, pdown, sleep, app_rst, full_rst;
  logic [7:0] addr, wdata, rdata, a, d;
  logic [3:0] chain;
  logic [1:0] proto;
  int         errors, cmp_count, seed;
  logic [7:0] shadow [0:47];

  adccfg_regbank uut (
    .I_CLK(clk), .I_RST(rst), .I_WR_EN(wr_en), .I_RD_EN(rd_en), .I_ADDR(addr),
    .I_WR_DATA(wdata), .I_RESET_PIN_N(pin_n), .I_CONVERT_START_SELECT(sel),
    .I_CONV_DONE(done), .O_RD_DATA(rdata), .O_RD_VALID(rvalid), .O_CHAIN_ID(chain),
    .O_SERIAL_PROTOCOL_SELECT(proto), .O_SUPPLY_ALARM_EN(sup_en),
    .O_INPUT_ALARM_EN(in_en), .O_POWER_DOWN(pdown), .O_LIGHT_SLEEP(sleep),
    .O_APP_RESET(app_rst), .O_FULL_RESET(full_rst));

  adccfg_host host (
    .i_clk(clk), .i_rd_data(rdata), .i_rd_valid(rvalid), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // expectations and checks
  function automatic logic [7:0] wmask(input logic [7:0] x);
    if (x == 8'h02) return 8'h0f;
    if (x == 8'h05) return 8'hff;
    if (x == 8'h08) return 8'h03;
    if ((x >= 8'h0c && x <= 8'h17) || (x >= 8'h20 && x <= 8'h2b)) return 8'hff;
    return 8'h00;
  endfunction : wmask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_pwr(input logic s, input logic i, input logic p);
    repeat (3) @(negedge clk);
    chk({5'h0, sup_en, in_en, pdown}, {5'h0, s, i, p});
  endtask : chk_pwr

  task automatic read_all;
    logic [7:0] v;
    for (int k = 0; k < 48; k++) begin
      host.rd(8'(k), v);
      chk(v, shadow[k]);
    end
    chk({4'h0, chain}, {4'h0, shadow[2][3:0]});
    chk({6'h0, proto}, {6'h0, shadow[8][1:0]});
  endtask : read_all

  task automatic clear_shadow;
    for (int k = 0; k < 48; k++) shadow[k] = 8'h00;
  endtask : clear_shadow

  task automatic pin_reset(input logic exp_app);
    logic sa, sf;
    sa = 1'b0;
    sf = 1'b0;
    @(negedge clk);
    pin_n = 1'b0;
    repeat (10) begin
      @(negedge clk);
      sa = sa | app_rst;
      sf = sf | full_rst;
    end
    pin_n = 1'b1;
    repeat (6) @(negedge clk);
    chk({7'h0, sa}, {7'h0, exp_app});
    chk({7'h0, sf}, {7'h0, ~exp_app});
  endtask : pin_reset

  task automatic pulse_done;
    @(negedge clk);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    @(negedge clk);
  endtask : pulse_done

  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask : tend

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // ==========================================================
  // watchdog: the whole sequence needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize;
  end

  // ==========================================================
  // main sequence
  initial begin
    errors = 0;
    cmp_count = 0;
    seed = 32'hbd3d8183;
    rst = 1'b1;
    pin_n = 1'b1;
    sel = 1'b1;
    done = 1'b0;
    clear_shadow;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    read_all;
    chk_pwr(1'b1, 1'b1, 1'b0);
    tend("reset");
    host.wr(8'h04, 8'h3f);
    host.wr(8'h05, 8'h68);
    host.wr(8'h04, 8'h3f);
    shadow[5] = 8'h68;
    read_all;
    tend("locked");
    repeat (80) begin
      a = 8'({$random(seed)} % 48);
      d = 8'($random(seed));
      // pins wander while light sleep is disabled; no sleep may follow
      sel  = 1'($random(seed));
      done = 1'($random(seed));
      if (a != 8'h04 && a != 8'h05) begin
        host.wr(a, d);
        shadow[a] = d & wmask(a);
      end else begin
        @(negedge clk);
      end
    end
    chk({7'h0, sleep}, 8'h00);
    sel  = 1'b1;
    done = 1'b0;
    read_all;
    tend("random");
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h08, {6'($random(seed)), 2'(c)});
      repeat (2) @(negedge clk);
      chk({6'h0, proto}, {6'h0, 2'(c)});
    end
    shadow[8] = 8'h03;
    tend("protocol");
    host.key_wr(8'hf9);
    shadow[4] = 8'h31;
    shadow[5] = 8'h69;
    chk_pwr(1'b0, 1'b0, 1'b1);
    read_all;
    host.key_wr(8'h00);
    chk_pwr(1'b1, 1'b1, 1'b0);
    tend("control");
    host.key_wr(8'h02);
    pulse_done;
    @(negedge clk);
    chk({7'h0, sleep}, 8'h01);
    sel = 1'b0;
    repeat (8) @(negedge clk);
    chk({7'h0, sleep}, 8'h00);
    sel = 1'b1;
    host.key_wr(8'h00);
    repeat (6) @(negedge clk);
    pulse_done;
    repeat (2) @(negedge clk);
    chk({7'h0, sleep}, 8'h00);
    tend("sleep");
    host.key_wr(8'h31);
    pin_reset(1'b0);
    clear_shadow;
    read_all;
    chk_pwr(1'b1, 1'b1, 1'b0);
    tend("full pin reset");
    host.key_wr(8'h06);
    host.wr(8'h08, 8'h02);
    host.wr(8'h02, 8'h05);
    host.wr(8'h0c, 8'haa);
    pin_reset(1'b1);
    clear_shadow;
    shadow[4] = 8'h06;
    shadow[8] = 8'h02;
    read_all;
    host.key_wr(8'h00);
    shadow[4] = 8'h04;
    shadow[5] = 8'h69;
    read_all;
    pin_reset(1'b1);
    tend("app pin reset");
    @(negedge clk);
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    clear_shadow;
    read_all;
    pin_reset(1'b0);
    tend("power-on");
    summarize;
  end
endmodule : tb_top
`default_nettype wire
